/* hdl/uart_rx_defines.svh */
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH

// Samples per bit period
`define URX_SAMPLES_NORMAL    5'h10
`define URX_SAMPLES_DOUBLE    5'h08

// First majority vote sample of a bit
`define URX_FIRST_VOTE_NORMAL 5'h08
`define URX_FIRST_VOTE_DOUBLE 5'h04

// Distance from first to last vote sample
`define URX_VOTE_SPAN         5'h02
`define URX_SAMPLE_STEP       5'h01

// Receive sampling select encodings
`define URX_MODE_NORMAL       2'h0
`define URX_MODE_DOUBLE       2'h1

// Legal data plus parity lengths
`define URX_MIN_BITS          4'h5
`define URX_MAX_BITS          4'ha

`endif

/* hdl/uart_rx_pkg.sv */
package uart_rx_pkg;

	// Gray coded along idle, start, align, data, stop
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_ALIGN = 3'b011,
		RX_DATA  = 3'b010,
		RX_STOP  = 3'b110
	} rx_state_type;

endpackage

/* hdl/uart_async_receive_sampling.sv */
`timescale 1ns/1ps
`include "uart_rx_defines.svh"

module uart_async_receive_sampling #(
	parameter int DIV_WIDTH = 16,
	parameter int MAX_BITS  = 10,
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic [1:0]           receive_sampling_select,
	input  wire logic [DIV_WIDTH-1:0] baudDivisor,
	input  wire logic [3:0]           frameBits,
	input  wire logic                 rxSerial,
	input  wire logic                 outReady,
	output logic                      outValid,
	output logic [MAX_BITS-1:0]       outData,
	output logic                      outFrameError,
	output logic                      overrun
);

	// Logic below is written for exactly ten bits and two entries
	generate
		if (MAX_BITS != 10 || BUF_DEPTH != 2 || DIV_WIDTH < 2) begin : g_chk
			$error("uart_async_receive_sampling: unsupported parameters");
		end
	endgenerate

	// Keeps a misprogrammed length inside the supported range
	function automatic logic [3:0] clampBits(input logic [3:0] b);
		if (b < `URX_MIN_BITS)
			return `URX_MIN_BITS;
		if (b > `URX_MAX_BITS)
			return `URX_MAX_BITS;
		return b;
	endfunction

	// Two of three high samples vote high
	function automatic logic majority(input logic [1:0] ones);
		return ones >= 2'h2;
	endfunction

	// Pin synchroniser; only the second stage is read
	logic rxMeta;
	logic rxSync;
	always_ff @(posedge ref_clk) begin
		rxMeta <= rxSerial;
		rxSync <= rxMeta;
	end

	// Sample tick divider, independent of mode
	logic [DIV_WIDTH-1:0] divCount;
	logic [DIV_WIDTH-1:0] next_divCount;
	logic                 tick;
	always_comb begin
		tick = (divCount == '0);
		if (!tick)
			next_divCount = divCount - 1'b1;
		else if (baudDivisor == '0)
			next_divCount = '0;
		else
			next_divCount = baudDivisor - 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			divCount <= '0;
		else
			divCount <= next_divCount;
	end

	// Mode decode; same tick with fewer samples doubles the rate
	logic       doubleMode;
	logic [4:0] samplesPerBit;
	logic [4:0] firstVote;
	logic [3:0] effBits;
	always_comb begin
		doubleMode = (receive_sampling_select == `URX_MODE_DOUBLE);
		samplesPerBit = doubleMode ? `URX_SAMPLES_DOUBLE
			: `URX_SAMPLES_NORMAL;
		firstVote = doubleMode ? `URX_FIRST_VOTE_DOUBLE
			: `URX_FIRST_VOTE_NORMAL;
		effBits = clampBits(frameBits);
	end
	// Only serial pins exist here, so no client select is offered

	// Receiver state
	uart_rx_pkg::rx_state_type state;
	uart_rx_pkg::rx_state_type next_state;
	logic [4:0]          sampleCount;
	logic [4:0]          next_sampleCount;
	logic [1:0]          ones;
	logic [1:0]          next_ones;
	logic [3:0]          bitIdx;
	logic [3:0]          next_bitIdx;
	logic [MAX_BITS-1:0] shiftData;
	logic [MAX_BITS-1:0] next_shiftData;
	logic                prevSample;
	logic                next_prevSample;
	logic [4:0]          curNum;
	logic [1:0]          onesNow;
	logic                voteNow;
	logic                lastVote;
	logic                push;
	logic                pushErr;

	// Sample scheduling and voting per bit period
	always_comb begin
		next_state = state;
		next_sampleCount = sampleCount;
		next_ones = ones;
		next_bitIdx = bitIdx;
		next_shiftData = shiftData;
		next_prevSample = prevSample;
		push = 1'b0;
		pushErr = 1'b0;
		curNum = sampleCount + `URX_SAMPLE_STEP;
		voteNow = (curNum >= firstVote)
			&& (curNum <= firstVote + `URX_VOTE_SPAN);
		lastVote = (curNum == firstVote + `URX_VOTE_SPAN);
		onesNow = ones + {1'b0, rxSync};
		if (tick) begin
			next_prevSample = rxSync;
			next_sampleCount = curNum;
			if (voteNow)
				next_ones = onesNow;
			case (state)
				uart_rx_pkg::RX_IDLE: begin
					next_sampleCount = `URX_SAMPLE_STEP;
					next_ones = 2'h0;
					if (prevSample && !rxSync)
						next_state = uart_rx_pkg::RX_START;
				end
				uart_rx_pkg::RX_START: begin
					if (lastVote) begin
						next_ones = 2'h0;
						next_bitIdx = 4'h0;
						next_shiftData = '0;
						if (!majority(onesNow))
							next_state = uart_rx_pkg::RX_ALIGN;
						else
							next_state = uart_rx_pkg::RX_IDLE;
					end
				end
				uart_rx_pkg::RX_ALIGN: begin
					if (curNum == samplesPerBit) begin
						next_sampleCount = 5'h00;
						next_state = uart_rx_pkg::RX_DATA;
					end
				end
				uart_rx_pkg::RX_DATA: begin
					if (lastVote) begin
						next_shiftData[bitIdx] = majority(onesNow);
						next_ones = 2'h0;
					end
					if (curNum == samplesPerBit) begin
						next_sampleCount = 5'h00;
						if (bitIdx == effBits - 4'h1)
							next_state = uart_rx_pkg::RX_STOP;
						else
							next_bitIdx = bitIdx + 4'h1;
					end
				end
				uart_rx_pkg::RX_STOP: begin
					// Hunting resumes on the very next sample
					if (lastVote) begin
						push = 1'b1;
						pushErr = !majority(onesNow);
						next_ones = 2'h0;
						next_state = uart_rx_pkg::RX_IDLE;
					end
				end
				default: next_state = uart_rx_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= uart_rx_pkg::RX_IDLE;
			sampleCount <= 5'h00;
			ones <= 2'h0;
			bitIdx <= 4'h0;
			shiftData <= '0;
			prevSample <= 1'b0;
		end else begin
			state <= next_state;
			sampleCount <= next_sampleCount;
			ones <= next_ones;
			bitIdx <= next_bitIdx;
			shiftData <= next_shiftData;
			prevSample <= next_prevSample;
		end
	end

	// Two-entry buffer: head drives the outputs, spare absorbs a stall.
	// The line cannot be paused, so a push into a full buffer with no pop
	// in the same cycle is dropped and reported on overrun instead.
	logic [MAX_BITS:0] spare;
	logic              spareValid;
	logic [MAX_BITS:0] next_spare;
	logic              next_spareValid;
	logic [MAX_BITS:0] next_head;
	logic              next_outValid;
	logic              next_overrun;
	logic              pop;
	logic              wrReady;
	logic              doPush;
	always_comb begin
		pop = outValid && outReady;
		wrReady = !spareValid || pop;
		doPush = push && wrReady;
		next_overrun = push && !wrReady;
		next_head = {outFrameError, outData};
		next_outValid = outValid;
		next_spare = spare;
		next_spareValid = spareValid;
		if (pop) begin
			next_outValid = spareValid;
			next_head = spare;
			next_spareValid = 1'b0;
		end
		if (doPush) begin
			if (!next_outValid) begin
				next_head = {pushErr, shiftData};
				next_outValid = 1'b1;
			end else begin
				next_spare = {pushErr, shiftData};
				next_spareValid = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			outValid <= 1'b0;
			outData <= '0;
			outFrameError <= 1'b0;
			spare <= '0;
			spareValid <= 1'b0;
			overrun <= 1'b0;
		end else begin
			outValid <= next_outValid;
			{outFrameError, outData} <= next_head;
			spare <= next_spare;
			spareValid <= next_spareValid;
			overrun <= next_overrun;
		end
	end

	// Checks
	sequence fallSeen;
		tick && state == uart_rx_pkg::RX_IDLE && prevSample && !rxSync;
	endsequence

	sequence startDecide;
		tick && state == uart_rx_pkg::RX_START && lastVote;
	endsequence

	sequence stopDecide;
		tick && state == uart_rx_pkg::RX_STOP && lastVote;
	endsequence

	a_mode_samples: assert property (@(posedge ref_clk) disable iff (srst)
		samplesPerBit == (receive_sampling_select == `URX_MODE_DOUBLE
			? 5'h08 : 5'h10))
		else $error("samples per bit wrong for mode");

	a_start_entry: assert property (@(posedge ref_clk) disable iff (srst)
		fallSeen |=> state == uart_rx_pkg::RX_START
			&& sampleCount == 5'h01)
		else $error("falling edge did not start detection");

	a_normal_votes: assert property (@(posedge ref_clk) disable iff (srst)
		(state == uart_rx_pkg::RX_START && !doubleMode && voteNow)
		|-> curNum >= 5'h08 && curNum <= 5'h0a)
		else $error("normal start votes outside eight to ten");

	a_double_votes: assert property (@(posedge ref_clk) disable iff (srst)
		(state == uart_rx_pkg::RX_START && doubleMode && voteNow)
		|-> curNum >= 5'h04 && curNum <= 5'h06)
		else $error("double start votes outside four to six");

	a_start_accept: assert property (@(posedge ref_clk) disable iff (srst)
		startDecide |=> (state == uart_rx_pkg::RX_ALIGN)
			== !majority($past(onesNow)))
		else $error("start accept or reject wrong");

	a_data_vote: assert property (@(posedge ref_clk) disable iff (srst)
		(tick && state == uart_rx_pkg::RX_DATA && lastVote)
		|=> shiftData[$past(bitIdx)] == majority($past(onesNow)))
		else $error("data bit not majority voted");

	a_stop_single: assert property (@(posedge ref_clk) disable iff (srst)
		stopDecide |=> state == uart_rx_pkg::RX_IDLE)
		else $error("receiver not hunting after stop vote");

	a_frame_error: assert property (@(posedge ref_clk) disable iff (srst)
		(stopDecide and (!outValid && !spareValid))
		|=> outValid && outFrameError == !majority($past(onesNow)))
		else $error("frame error flag wrong");

	a_bit_range: assert property (@(posedge ref_clk) disable iff (srst)
		state == uart_rx_pkg::RX_DATA |-> bitIdx < effBits
			&& effBits >= 4'h5 && effBits <= 4'ha)
		else $error("bit index outside frame length");

	a_buffer_hold: assert property (@(posedge ref_clk) disable iff (srst)
		outValid && !outReady |=> outValid && $stable(outData)
			&& $stable(outFrameError))
		else $error("stalled word changed or lost");

endmodule

/* verif/serial_sender.sv */
`timescale 1ns/1ps

module serial_sender (
	input  wire logic ref_clk,
	output logic      rxSerial
);
	// Idle line rests high, as behind a pull-up
	initial rxSerial = 1'b1;

	// Drive one level for n clocks; callers start at a falling edge
	task automatic hold_line(input logic lvl, input int n);
		rxSerial = lvl;
		repeat (n) @(negedge ref_clk);
	endtask

	// One frame at exactly the receiver's bit time
	task automatic send_frame(input logic [9:0] data, input int nBits,
			input int bitCyc, input logic stopLvl, input int stopCyc);
		hold_line(1'b0, bitCyc);
		for (int i = 0; i < nBits; i++) begin
			hold_line(data[i], bitCyc); // Least significant bit first
		end
		hold_line(stopLvl, stopCyc); // Callers keep the gap
		rxSerial = 1'b1;
	endtask
endmodule

/* verif/uart_async_receive_sampling_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	errorCnt++; $display("Error %s expected %h seen %h", nm, ex, got); \
	end end

module uart_async_receive_sampling_tb;
	localparam int DIV = 4;
	logic        ref_clk;
	logic        srst;
	logic [1:0]  mode;
	logic [15:0] baudDivisor;
	logic [3:0]  frameBits;
	logic        rxSerial;
	logic        outReady;
	logic        outValid;
	logic [9:0]  outData;
	logic        outFrameError;
	logic        overrun;
	int          errorCnt;
	int          compares;
	int          ovrCnt;
	int          ovr0;
	int          rdyMode;
	int          div;
	logic        rdyNext;
	logic [10:0] expQ[$];

	uart_async_receive_sampling uut (
		.ref_clk(ref_clk), .srst(srst), .receive_sampling_select(mode),
		.baudDivisor(baudDivisor), .frameBits(frameBits),
		.rxSerial(rxSerial), .outReady(outReady), .outValid(outValid),
		.outData(outData), .outFrameError(outFrameError),
		.overrun(overrun)
	);

	serial_sender tx (.ref_clk(ref_clk), .rxSerial(rxSerial));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Pick ready first: the pop happens at the edge after this one
	always @(negedge ref_clk) begin
		if (overrun === 1'b1) ovrCnt++;
		rdyNext = (rdyMode == 0) ? 1'b0 :
			(rdyMode == 2) ? 1'b1 : 1'($urandom);
		if (outValid === 1'b1 && rdyNext === 1'b1) begin
			if (expQ.size() == 0) `CHK("spurious word", 1'b0, 1'b1)
			else begin
				`CHK("outData", expQ[0][9:0], outData)
				`CHK("outFrameError", expQ[0][10], outFrameError)
				void'(expQ.pop_front());
			end
		end
		outReady <= rdyNext;
	end

	// Expected word queued before sending, since the push beats frame end
	task automatic frame(input logic [1:0] m, input int nb,
			input logic stopLvl, input int stopCyc);
		logic [9:0] d;
		int         bc;
		d = 10'($urandom) & 10'((1 << nb) - 1);
		bc = div * ((m == 2'h1) ? 8 : 16);
		baudDivisor = 16'(div);
		mode = m;
		frameBits = 4'(nb);
		expQ.push_back({~stopLvl, d});
		tx.send_frame(d, nb, bc, stopLvl, (stopCyc < 0) ? bc : stopCyc);
	endtask

	task automatic drain();
		rdyMode = 2;
		for (int i = 0; i < 300 && expQ.size() != 0; i++) begin
			@(negedge ref_clk);
		end
		`CHK("pending words", 0, expQ.size())
	endtask

	task automatic print_verdict();
		$display("Compares %0d errors %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard well beyond the expected run of about 17k cycles
	initial begin
		#300_000;
		errorCnt++;
		print_verdict();
	end

	initial begin
		srst = 1'b1;
		mode = 2'h0;
		div = DIV;
		baudDivisor = 16'(DIV);
		frameBits = 4'h8;
		outReady = 1'b0;
		rdyMode = 1;
		void'($urandom(252));
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		tx.hold_line(1'b1, 16 * DIV);
		// Every length in all modes and several divisors; 2, 3 act normal
		for (int nb = 5; nb <= 10; nb++) begin
			div = 2 + nb % 3;
			for (int m = 0; m < 4; m++) begin
				frame(2'(m), nb, 1'b1, -1);
				tx.hold_line(1'b1, 8 * DIV);
			end
		end
		div = DIV;
		// Low first stop, then a high extra stop that must be ignored
		frame(2'h0, 8, 1'b0, -1);
		tx.hold_line(1'b1, 16 * DIV);
		frame(2'h1, 6, 1'b0, -1);
		tx.hold_line(1'b1, 8 * DIV);
		// Short glitches must be rejected, then a clean frame follows
		mode = 2'h0;
		tx.hold_line(1'b0, 4 * DIV);
		tx.hold_line(1'b1, 32 * DIV);
		mode = 2'h1;
		tx.hold_line(1'b0, 2 * DIV);
		tx.hold_line(1'b1, 16 * DIV);
		frame(2'h1, 8, 1'b1, -1);
		tx.hold_line(1'b1, 8 * DIV);
		// Next start falls just after the stop votes
		rdyMode = 2;
		repeat (3) frame(2'h0, 8, 1'b1, 10 * DIV + 3);
		tx.hold_line(1'b1, 16 * DIV);
		drain();
		// Stalled sink: third word is dropped with one overrun pulse
		rdyMode = 0;
		ovr0 = ovrCnt;
		repeat (3) frame(2'h0, 7, 1'b1, -1);
		void'(expQ.pop_back());
		tx.hold_line(1'b1, 16 * DIV);
		`CHK("overrun pulses", 1, ovrCnt - ovr0)
		drain();
		// Reset in mid-run with a word pending empties the output
		rdyMode = 0;
		frame(2'h0, 5, 1'b1, -1);
		tx.hold_line(1'b1, 4 * DIV);
		srst = 1'b1;
		expQ.delete();
		repeat (2) @(negedge ref_clk);
		srst = 1'b0;
		`CHK("outValid after reset", 1'b0, outValid)
		`CHK("outData after reset", 10'h000, outData)
		tx.hold_line(1'b1, 16 * DIV);
		frame(2'h0, 9, 1'b1, -1);
		tx.hold_line(1'b1, 16 * DIV);
		drain();
		print_verdict();
	end
endmodule
